// >>> rtl/cso_settle_core.v
// channel settling timers, frequency shift registers and result flags
// Function
// - channel 2 shift register: 16-bit, read/write, resets to zero, subtracted from channel 2 measurement words.
// - channel 3 shift register: 16-bit, read/write, resets to zero, subtracted from channel 3 measurement words.
// - wait the programmed settling interval before a channel conversion starts.
// - unsettled amplitude at conversion start raises amplitude error when reporting enabled.
// - settle count zero or one gives 32 reference periods.
// - settle count two and above gives count times 16 reference periods.
// - each settle count is 16-bit read/write, bits 15:0, reset zero.
// - reference frequency is input clock over the nonzero 10-bit divider.
// - amplitude error shows read-only in result register, cleared by host read.
`timescale 1ns/1ps
`include "cso_defines.vh"

module cso_settle_core (
  input  wire        ref_clk,
  input  wire        srst,
  input  wire [7:0]  regAddr,
  input  wire [15:0] regWrData,
  input  wire        regWrEn,
  input  wire        regRdEn,
  output reg  [15:0] regRdData,
  output reg         regRdValid,
  input  wire [3:0]  convReq,
  input  wire [3:0]  ampSettled,
  input  wire        ampErrReportEn,
  input  wire        measValid,
  input  wire [1:0]  measChan,
  input  wire [15:0] measWord,
  output wire [3:0]  settleBusy,
  output wire [3:0]  convStart
);

  // configuration registers
  reg  [15:0] chan2FreqShift_q;
  reg  [15:0] chan3FreqShift_q;
  reg  [15:0] chan0SettleInterval_q;
  reg  [15:0] chan1SettleInterval_q;
  reg  [15:0] chan2SettleInterval_q;
  reg  [15:0] chan3SettleInterval_q;
  reg  [15:0] chan0ReferenceDivider_q;
  reg  [15:0] chan1ReferenceDivider_q;
  reg  [15:0] chan2ReferenceDivider_q;
  reg  [15:0] chan3ReferenceDivider_q;

  // result and flag state
  reg  [11:0] result0_q;
  reg  [11:0] result1_q;
  reg  [11:0] result2_q;
  reg  [11:0] result3_q;
  reg  [3:0]  ampFault_q;
  reg  [3:0]  ampFault_d;

  // combinational helpers
  reg  [15:0] rdMux;
  reg  [3:0]  rdClear;
  reg  [15:0] selShift;
  reg  [15:0] shiftedWord;
  wire [3:0]  aeSet;

  // register writes
  always @(posedge ref_clk) begin
    if (srst) begin
      chan2FreqShift_q        <= `CSO_RST_SHIFT;
      chan3FreqShift_q        <= `CSO_RST_SHIFT;
      chan0SettleInterval_q   <= `CSO_RST_SETTLE;
      chan1SettleInterval_q   <= `CSO_RST_SETTLE;
      chan2SettleInterval_q   <= `CSO_RST_SETTLE;
      chan3SettleInterval_q   <= `CSO_RST_SETTLE;
      chan0ReferenceDivider_q <= `CSO_RST_DIV;
      chan1ReferenceDivider_q <= `CSO_RST_DIV;
      chan2ReferenceDivider_q <= `CSO_RST_DIV;
      chan3ReferenceDivider_q <= `CSO_RST_DIV;
    end else if (regWrEn) begin
      case (regAddr)
        `CSO_ADDR_SHIFT2: begin
          chan2FreqShift_q <= regWrData;
        end
        `CSO_ADDR_SHIFT3: begin
          chan3FreqShift_q <= regWrData;
        end
        `CSO_ADDR_SETTLE0: begin
          chan0SettleInterval_q <= regWrData;
        end
        `CSO_ADDR_SETTLE1: begin
          chan1SettleInterval_q <= regWrData;
        end
        `CSO_ADDR_SETTLE2: begin
          chan2SettleInterval_q <= regWrData;
        end
        `CSO_ADDR_SETTLE3: begin
          chan3SettleInterval_q <= regWrData;
        end
        `CSO_ADDR_DIV0: begin
          chan0ReferenceDivider_q <= regWrData;
        end
        `CSO_ADDR_DIV1: begin
          chan1ReferenceDivider_q <= regWrData;
        end
        `CSO_ADDR_DIV2: begin
          chan2ReferenceDivider_q <= regWrData;
        end
        `CSO_ADDR_DIV3: begin
          chan3ReferenceDivider_q <= regWrData;
        end
        default: begin
          // result registers are read-only; other offsets ignore writes
        end
      endcase
    end
  end

  // one settling timer per channel
  cso_settle_timer uTimer0 (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .startReq    (convReq[0]),
    .refDiv      (chan0ReferenceDivider_q[`CSO_DIV_MSB:`CSO_DIV_LSB]),
    .settleCount (chan0SettleInterval_q),
    .busy        (settleBusy[0]),
    .done        (convStart[0])
  );

  cso_settle_timer uTimer1 (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .startReq    (convReq[1]),
    .refDiv      (chan1ReferenceDivider_q[`CSO_DIV_MSB:`CSO_DIV_LSB]),
    .settleCount (chan1SettleInterval_q),
    .busy        (settleBusy[1]),
    .done        (convStart[1])
  );

  cso_settle_timer uTimer2 (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .startReq    (convReq[2]),
    .refDiv      (chan2ReferenceDivider_q[`CSO_DIV_MSB:`CSO_DIV_LSB]),
    .settleCount (chan2SettleInterval_q),
    .busy        (settleBusy[2]),
    .done        (convStart[2])
  );

  cso_settle_timer uTimer3 (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .startReq    (convReq[3]),
    .refDiv      (chan3ReferenceDivider_q[`CSO_DIV_MSB:`CSO_DIV_LSB]),
    .settleCount (chan3SettleInterval_q),
    .busy        (settleBusy[3]),
    .done        (convStart[3])
  );

  // amplitude sampled in the very cycle the conversion begins
  assign aeSet = convStart & ~ampSettled & {4{ampErrReportEn}};

  // read mux and read-side clears
  always @* begin
    rdMux   = 16'h0000;
    rdClear = 4'h0;
    case (regAddr)
      `CSO_ADDR_RESULT0: begin
        rdMux      = {3'h0, ampFault_q[0], result0_q};
        rdClear[0] = 1'b1;
      end
      `CSO_ADDR_RESULT1: begin
        rdMux      = {3'h0, ampFault_q[1], result1_q};
        rdClear[1] = 1'b1;
      end
      `CSO_ADDR_RESULT2: begin
        rdMux      = {3'h0, ampFault_q[2], result2_q};
        rdClear[2] = 1'b1;
      end
      `CSO_ADDR_RESULT3: begin
        rdMux      = {3'h0, ampFault_q[3], result3_q};
        rdClear[3] = 1'b1;
      end
      `CSO_ADDR_SHIFT2: begin
        rdMux = chan2FreqShift_q;
      end
      `CSO_ADDR_SHIFT3: begin
        rdMux = chan3FreqShift_q;
      end
      `CSO_ADDR_SETTLE0: begin
        rdMux = chan0SettleInterval_q;
      end
      `CSO_ADDR_SETTLE1: begin
        rdMux = chan1SettleInterval_q;
      end
      `CSO_ADDR_SETTLE2: begin
        rdMux = chan2SettleInterval_q;
      end
      `CSO_ADDR_SETTLE3: begin
        rdMux = chan3SettleInterval_q;
      end
      `CSO_ADDR_DIV0: begin
        rdMux = chan0ReferenceDivider_q;
      end
      `CSO_ADDR_DIV1: begin
        rdMux = chan1ReferenceDivider_q;
      end
      `CSO_ADDR_DIV2: begin
        rdMux = chan2ReferenceDivider_q;
      end
      `CSO_ADDR_DIV3: begin
        rdMux = chan3ReferenceDivider_q;
      end
      default: begin
        rdMux = 16'h0000;
      end
    endcase
  end

  // set beats read-clear so a fault landing on the read is kept
  always @* begin
    ampFault_d = ampFault_q;
    if (regRdEn) begin
      ampFault_d = ampFault_d & ~rdClear;
    end
    ampFault_d = ampFault_d | aeSet;
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      ampFault_q <= 4'h0;
      regRdData  <= 16'h0000;
      regRdValid <= 1'b0;
    end else begin
      ampFault_q <= ampFault_d;
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= rdMux;
      end
    end
  end

  // shift applies to channels 2 and 3; channels 0 and 1 use none here
  always @* begin
    selShift = 16'h0000;
    case (measChan)
      2'h2: begin
        selShift = chan2FreqShift_q;
      end
      2'h3: begin
        selShift = chan3FreqShift_q;
      end
      default: begin
        selShift = 16'h0000;
      end
    endcase
    // clamp at zero rather than wrap a below-shift reading to full scale
    if (measWord >= selShift) begin
      shiftedWord = measWord - selShift;
    end else begin
      shiftedWord = 16'h0000;
    end
  end

  // results keep the upper 12 bits of the shifted word
  always @(posedge ref_clk) begin
    if (srst) begin
      result0_q <= `CSO_RST_RESULT;
      result1_q <= `CSO_RST_RESULT;
      result2_q <= `CSO_RST_RESULT;
      result3_q <= `CSO_RST_RESULT;
    end else if (measValid) begin
      case (measChan)
        2'h0: begin
          result0_q <= shiftedWord[15:`CSO_RES_DROP];
        end
        2'h1: begin
          result1_q <= shiftedWord[15:`CSO_RES_DROP];
        end
        2'h2: begin
          result2_q <= shiftedWord[15:`CSO_RES_DROP];
        end
        default: begin
          result3_q <= shiftedWord[15:`CSO_RES_DROP];
        end
      endcase
    end
  end

endmodule

// >>> rtl/cso_settle_timer.v
// per-channel reference tick divider and settling interval counter
`timescale 1ns/1ps
`include "cso_defines.vh"

module cso_settle_timer (
  input  wire        ref_clk,
  input  wire        srst,
  input  wire        startReq,
  input  wire [9:0]  refDiv,
  input  wire [15:0] settleCount,
  output wire        busy,
  output wire        done
);

  reg  [9:0]  divCnt_q;
  reg  [19:0] tickCnt_q;
  reg         busy_q;
  reg         done_q;
  wire [9:0]  effDiv;
  wire        refTick;
  wire [19:0] target;

  // divider of zero is not allowed; treat it as one so the timer never hangs
  assign effDiv = (refDiv == 10'h000) ? 10'h001 : refDiv;
  assign refTick = (divCnt_q == (effDiv - 10'h001));

  assign target = (settleCount <= `CSO_SETTLE_SMALL_MAX) ?
                  `CSO_SETTLE_MIN_TICKS :
                  {settleCount, `CSO_SETTLE_MULT_PAD};

  always @(posedge ref_clk) begin
    if (srst) begin
      divCnt_q  <= 10'h000;
      tickCnt_q <= 20'h00000;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (startReq) begin
        // a new request restarts the interval from the latest settings
        divCnt_q  <= 10'h000;
        tickCnt_q <= target;
        busy_q    <= 1'b1;
      end else if (busy_q) begin
        if (refTick) begin
          divCnt_q <= 10'h000;
          if (tickCnt_q == 20'h00001) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
          tickCnt_q <= tickCnt_q - 20'h00001;
        end else begin
          divCnt_q <= divCnt_q + 10'h001;
        end
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule

// >>> shared/cso_defines.vh
// register map, reset values and timing constants for the settle/shift block
`ifndef CSO_DEFINES_VH
`define CSO_DEFINES_VH

// register offsets on the register port
`define CSO_ADDR_RESULT0     8'h00
`define CSO_ADDR_RESULT1     8'h02
`define CSO_ADDR_RESULT2     8'h04
`define CSO_ADDR_RESULT3     8'h06
`define CSO_ADDR_SHIFT2      8'h0e
`define CSO_ADDR_SHIFT3      8'h0f
`define CSO_ADDR_SETTLE0     8'h10
`define CSO_ADDR_SETTLE1     8'h11
`define CSO_ADDR_SETTLE2     8'h12
`define CSO_ADDR_SETTLE3     8'h13
`define CSO_ADDR_DIV0        8'h14
`define CSO_ADDR_DIV1        8'h15
`define CSO_ADDR_DIV2        8'h16
`define CSO_ADDR_DIV3        8'h17

// reset values
`define CSO_RST_SHIFT        16'h0000
`define CSO_RST_SETTLE       16'h0000
`define CSO_RST_DIV          16'h0000
`define CSO_RST_RESULT       12'h000

// field layout
`define CSO_DIV_MSB          9
`define CSO_DIV_LSB          0
`define CSO_AE_BIT           12
`define CSO_RES_MSB          11
`define CSO_RES_DROP         4

// settling interval
`define CSO_SETTLE_SMALL_MAX 16'h0001
`define CSO_SETTLE_MIN_TICKS 20'h00020
`define CSO_SETTLE_MULT_PAD  4'h0

`endif

// >>> testbench/cso_settle_core_chk.sv
// port checker for the settle/shift core
`timescale 1ns/1ps
module cso_settle_core_chk (
  input wire logic        ref_clk, srst, regWrEn, regRdEn, regRdValid,
  input wire logic        ampErrReportEn, measValid,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWrData, regRdData, measWord,
  input wire logic [3:0]  convReq, ampSettled, settleBusy, convStart,
  input wire logic [1:0]  measChan
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_rv; regRdEn |=> regRdValid; endproperty
  a_rv: assert property (p_rv) else $error("read valid missing");
  property p_sb; |convReq |=> (settleBusy & $past(convReq)) == $past(convReq); endproperty
  a_sb: assert property (p_sb) else $error("busy not raised");
  property p_one; |convStart |=> (convStart & $past(convStart)) == 4'h0; endproperty
  a_one: assert property (p_one) else $error("start too long");
  property p_min; convReq[0] |=> !convStart[0] [*8]; endproperty
  a_min: assert property (p_min) else $error("start too early");
  property p_um; regRdEn && regAddr == 8'h20 |=> regRdData == 16'h0000; endproperty
  a_um: assert property (p_um) else $error("unmapped read");
  property p_rw;
    regWrEn && regAddr >= 8'h0e && regAddr <= 8'h13 ##2 regRdEn && !regWrEn
      && regAddr == $past(regAddr, 2) |=> regRdData == $past(regWrData, 3);
  endproperty
  a_rw: assert property (p_rw) else $error("readback wrong");
  property p_hi; regRdEn && regAddr == 8'h04 |=> regRdData[15:13] == 3'h0; endproperty
  a_hi: assert property (p_hi) else $error("result top bits");
  property p_ae;
    convStart[2] && !ampSettled[2] && ampErrReportEn ##[1:8] regRdEn && regAddr == 8'h04
      |=> regRdData[12];
  endproperty
  a_ae: assert property (p_ae) else $error("fault not flagged");
  property p_clr;
    regRdEn && regAddr == 8'h04 && !convStart[2] ##2 regRdEn && regAddr == 8'h04
      |=> !regRdData[12];
  endproperty
  a_clr: assert property (p_clr) else $error("fault not cleared");
  c_start: cover property (convStart[2]);
  c_ae: cover property (p_ae);
  c_rw: cover property (p_rw);
endmodule
bind cso_settle_core cso_settle_core_chk u_chk (.ref_clk(ref_clk), .srst(srst),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdValid(regRdValid), .measValid(measValid),
  .ampErrReportEn(ampErrReportEn), .regAddr(regAddr), .regWrData(regWrData),
  .regRdData(regRdData), .measWord(measWord), .convReq(convReq), .ampSettled(ampSettled),
  .settleBusy(settleBusy), .convStart(convStart), .measChan(measChan));

// >>> testbench/cso_tank_model.sv
// sensor tank model: settle status and one measurement per cycle with a conversion start, for the highest starting channel
`timescale 1ns/1ps
module cso_tank_model (
  input  wire        ref_clk,
  input  wire [3:0]  slowMask,
  input  wire [15:0] word,
  input  wire [3:0]  convStart,
  output wire [3:0]  ampSettled,
  output reg         measValid,
  output reg  [1:0]  measChan,
  output reg  [15:0] measWord
);
  assign ampSettled = ~slowMask; // slow tanks never settle in time
  initial begin
    measValid = 1'b0;
    measChan = 2'h0;
    measWord = 16'h0000;
  end
  always @(posedge ref_clk) begin
    measValid <= |convStart;
    measChan <= convStart[3] ? 2'h3 : convStart[2] ? 2'h2 : convStart[1] ? 2'h1 : 2'h0;
    measWord <= (|convStart) ? word : ~measWord; // idle word toggles, never stale
  end
endmodule

// >>> testbench/tb.sv
// testbench for the settle/shift core
`timescale 1ns/1ps
module tb;
  reg         ref_clk, srst, regWrEn, regRdEn, ampErrReportEn;
  reg  [7:0]  regAddr;
  reg  [15:0] regWrData, word;
  reg  [3:0]  convReq, slowMask;
  wire [15:0] regRdData, measWord;
  wire [3:0]  ampSettled, settleBusy, convStart;
  wire [1:0]  measChan;
  wire        regRdValid, measValid;
  integer     fail_count, compares, i, n;
  cso_settle_core dut (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .convReq(convReq), .ampSettled(ampSettled),
    .ampErrReportEn(ampErrReportEn), .measValid(measValid), .measChan(measChan),
    .measWord(measWord), .settleBusy(settleBusy), .convStart(convStart));
  cso_tank_model tank (.ref_clk(ref_clk), .slowMask(slowMask), .word(word),
    .convStart(convStart), .ampSettled(ampSettled), .measValid(measValid),
    .measChan(measChan), .measWord(measWord));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task chk(input [15:0] exp, input [15:0] seen, input string what);
    compares = compares + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(negedge ref_clk); regWrEn = 1'b1; regAddr = a; regWrData = d;
    @(negedge ref_clk); regWrEn = 1'b0;
  endtask
  task rd(input [7:0] a, input [15:0] exp);
    @(negedge ref_clk); regRdEn = 1'b1; regAddr = a;
    @(negedge ref_clk); regRdEn = 1'b0;
    chk(16'h0001, {15'h0000, regRdValid}, "read valid");
    chk(exp, regRdData, "read data");
  endtask
  // program count and divider, request, count cycles to conversion start
  task settle(input [1:0] c, input [15:0] cnt, input [15:0] dv, input [15:0] exp);
    wr(8'h10 + c, cnt);
    wr(8'h14 + c, dv);
    @(negedge ref_clk); convReq[c] = 1'b1;
    // n counts edges after the request edge, so this first look is edge zero
    @(negedge ref_clk); convReq = 4'h0; n = 0;
    chk(16'h0001, {15'h0000, settleBusy[c]}, "settle busy");
    while (convStart[c] !== 1'b1 && n < 5000) begin
      @(negedge ref_clk); n = n + 1;
    end
    chk(exp, n[15:0], "settle cycles");
    chk(16'h0000, {15'h0000, settleBusy[c]}, "settle busy end");
    repeat (3) @(negedge ref_clk); // let the measurement land
  endtask
  task wrap_up;
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #1000000;
    fail_count = fail_count + 1;
    wrap_up;
  end
  initial begin
    srst = 1'b1; regWrEn = 1'b0; regRdEn = 1'b0; regAddr = 8'h00; regWrData = 16'h0000;
    convReq = 4'h0; slowMask = 4'h4; word = 16'hc000; ampErrReportEn = 1'b1;
    fail_count = 0; compares = 0;
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    for (i = 14; i < 20; i = i + 1) rd(i[7:0], 16'h0000);
    rd(8'h20, 16'h0000);
    for (i = 14; i < 20; i = i + 1) begin
      wr(i[7:0], 16'ha5c3 ^ i[15:0]);
      rd(i[7:0], 16'ha5c3 ^ i[15:0]);
    end
    wr(8'h04, 16'hffff);
    rd(8'h04, 16'h0000);
    settle(2'h0, 16'h0000, 16'h0001, 16'd32);
    settle(2'h1, 16'h0001, 16'h0002, 16'd64);
    rd(8'h02, 16'h0c00);
    settle(2'h0, 16'h0003, 16'h0000, 16'd48);
    settle(2'h3, 16'h0005, 16'h0403, 16'd240);
    rd(8'h06, 16'h01a3);
    settle(2'h2, 16'h0002, 16'h0001, 16'd32);
    rd(8'h04, 16'h11a3);
    rd(8'h04, 16'h01a3);
    ampErrReportEn = 1'b0;
    settle(2'h2, 16'h0002, 16'h0001, 16'd32);
    rd(8'h04, 16'h01a3);
    wr(8'h0f, 16'hffff);
    settle(2'h3, 16'h0000, 16'h0001, 16'd32);
    rd(8'h06, 16'h0000);
    @(negedge ref_clk); srst = 1'b1;
    @(negedge ref_clk); srst = 1'b0;
    rd(8'h0f, 16'h0000);
    rd(8'h12, 16'h0000);
    wrap_up;
  end
endmodule
